// ### core/interval_counter_modes.sv
// Three-channel six-mode interval down-counter with an AXI4-Lite register port.
//
// Functional notes
// - Zero count means full 65536 cycle, 10000 in decimal.
// - Mode 0 output low until zero.
// - Mode 0 gate pauses counting only.
// - Mode 0 output rises N+1 clocks after write.
// - Mode 0 first byte halts, output low.
// - Mode 0 loads even while gate low.
// - Mode 1 trigger gives single N-clock low pulse.
// - Mode 1 retrigger reloads; writes wait for trigger.
// - Mode 2 one-clock low at count one.
// - Mode 2 low gate forces high, trigger reloads.
// - Mode 2 new count at trigger or cycle end.
// - Mode 3 square wave of period N, N-1 for odd N.
// - Mode 3 low gate forces high, trigger reloads.
// - Mode 3 new count at trigger or half end.
// - Mode 3 even count steps by two.
// - Mode 3 odd count high (N-1)/2, same as low.
// - Mode 4 one-clock strobe at zero.
// - Mode 4 strobe N+1 clocks after write.
// - Mode 4 first byte harmless; second retriggers.
// - Mode 5 gate trigger, strobe N+1 later.
// - Mode 5 writes wait for next trigger.
// - Byte format selects LSB, MSB or both.
// - Decimal option counts four BCD digits.
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`default_nettype none
module interval_counter_modes
    import pit_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                srst,
    input  wire logic [NUM_CH-1:0]   count_clk_fall,
    input  wire logic [NUM_CH-1:0]   count_trigger_inputs,
    output var  logic [NUM_CH-1:0]   timer_outputs,
    input  wire logic [3:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output var  logic                s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output var  logic                s_axi_wready,
    output var  logic [1:0]          s_axi_bresp,
    output var  logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [3:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output var  logic                s_axi_arready,
    output var  logic [31:0]         s_axi_rdata,
    output var  logic [1:0]          s_axi_rresp,
    output var  logic                s_axi_rvalid,
    input  wire logic                s_axi_rready
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        chan_t [NUM_CH-1:0] ch;
        logic               aw_got;
        logic [3:0]         aw_addr;
        logic               w_got;
        logic [7:0]         w_data;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
        logic               awready;
        logic               wready;
        logic               arready;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    function automatic logic [15:0] dec_by(input logic [15:0] v, input logic bcd, input logic two);
        logic [15:0] r;
        logic        borrow;
        r = v;
        if (!bcd) begin
            r = v - (two ? 16'h0002 : 16'h0001);
        end else begin
            for (int k = 0; k < (two ? 2 : 1); k++) begin
                borrow = 1'b1;
                for (int d = 0; d < 4; d++) begin
                    if (borrow) begin
                        if (r[d*4 +: 4] == 4'h0) begin
                            r[d*4 +: 4] = 4'h9;
                        end else begin
                            r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
                            borrow = 1'b0;
                        end
                    end
                end
            end
        end
        return r;
    endfunction

    // Mode 3 loads odd counts less one so that halves step by two.
    function automatic logic [15:0] sq_load(input logic [15:0] v, input logic bcd);
        return v[0] ? dec_by(v, bcd, 1'b0) : v;
    endfunction

    logic       wr_fire;
    logic       rd_fire;
    logic [1:0] wr_idx;
    logic [1:0] rd_idx;

    always_comb begin
        nxt_st  = st_ff;
        wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
        wr_idx  = st_ff.aw_addr[3:2];
        rd_fire = s_axi_arvalid && st_ff.arready;
        rd_idx  = s_axi_araddr[3:2];

        // ------------------------------------------------------------
        // AXI4-Lite slave
        // ------------------------------------------------------------
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_got  = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_got  = 1'b1;
            nxt_st.w_data = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
        end
        nxt_st.awready = !nxt_st.aw_got && !st_ff.bvalid;
        nxt_st.wready  = !nxt_st.w_got && !st_ff.bvalid;
        if (wr_fire) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = (st_ff.aw_addr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
            nxt_st.awready = 1'b0;
            nxt_st.wready  = 1'b0;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid  = 1'b0;
            nxt_st.awready = 1'b1;
            nxt_st.wready  = 1'b1;
        end
        if (rd_fire) begin
            nxt_st.arready = 1'b0;
            nxt_st.rvalid  = 1'b1;
            nxt_st.rresp   = RESP_OKAY;
            nxt_st.rdata   = 32'h0000_0000;
            if (s_axi_araddr[1:0] != 2'h0) begin
                nxt_st.rresp = RESP_SLVERR;
            end else if (s_axi_araddr == OFS_CTRL) begin
                for (int c = 0; c < NUM_CH; c++) begin
                    nxt_st.rdata[c] = st_ff.ch[c].out;
                end
            end else begin
                nxt_st.rdata[15:0]  = st_ff.ch[rd_idx].elem;
                nxt_st.rdata[17:16] = st_ff.ch[rd_idx].fmt;
                nxt_st.rdata[20:18] = st_ff.ch[rd_idx].mode;
                nxt_st.rdata[21]    = st_ff.ch[rd_idx].bcd;
                nxt_st.rdata[22]    = st_ff.ch[rd_idx].out;
            end
        end
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid  = 1'b0;
            nxt_st.arready = 1'b1;
        end

        // ------------------------------------------------------------
        // Counter channels
        // ------------------------------------------------------------
        for (int c = 0; c < NUM_CH; c++) begin
            logic        trig;
            logic        tick;
            logic        gate;
            logic [15:0] nv;
            logic        at_one;
            gate = count_trigger_inputs[c];
            trig = gate && !st_ff.ch[c].gate_q;
            tick = count_clk_fall[c];
            nv   = st_ff.ch[c].elem;
            at_one = 1'b0;
            nxt_st.ch[c].gate_q = gate;
            if (trig) begin
                nxt_st.ch[c].trig_pend = 1'b1;
            end
            if (!gate && (st_ff.ch[c].mode[1] == 1'b1)) begin
                nxt_st.ch[c].out = 1'b1;
            end

            if (tick) begin
                nxt_st.ch[c].trig_pend = 1'b0;
                unique case (st_ff.ch[c].mode[1:0] | {st_ff.ch[c].mode[2] & !st_ff.ch[c].mode[1], 2'h0})
                    default: begin
                    end
                endcase
                if (st_ff.ch[c].armed) begin
                    unique case ({st_ff.ch[c].mode[1] ? 1'b0 : st_ff.ch[c].mode[2], st_ff.ch[c].mode[1:0]})
                        3'h0, 3'h4: begin
                            if (st_ff.ch[c].load_pend) begin
                                nxt_st.ch[c].elem      = st_ff.ch[c].hold;
                                nxt_st.ch[c].load_pend = 1'b0;
                                nxt_st.ch[c].running   = 1'b1;
                                nxt_st.ch[c].strobe_done = 1'b0;
                            end else if (gate && st_ff.ch[c].running) begin
                                nv = dec_by(st_ff.ch[c].elem, st_ff.ch[c].bcd, 1'b0);
                                nxt_st.ch[c].elem = nv;
                                if (st_ff.ch[c].mode[2]) begin
                                    nxt_st.ch[c].out = !(nv == 16'h0000 && !st_ff.ch[c].strobe_done);
                                    if (nv == 16'h0000) begin
                                        nxt_st.ch[c].strobe_done = 1'b1;
                                    end
                                end else if (nv == 16'h0000) begin
                                    nxt_st.ch[c].out = 1'b1;
                                end
                            end else if (st_ff.ch[c].mode[2]) begin
                                nxt_st.ch[c].out = 1'b1;
                            end
                        end
                        3'h1, 3'h5: begin
                            if (st_ff.ch[c].trig_pend || trig) begin
                                nxt_st.ch[c].elem    = st_ff.ch[c].hold;
                                nxt_st.ch[c].running = 1'b1;
                                nxt_st.ch[c].strobe_done = 1'b0;
                                nxt_st.ch[c].out     = st_ff.ch[c].mode[2];
                            end else if (st_ff.ch[c].running) begin
                                nv = dec_by(st_ff.ch[c].elem, st_ff.ch[c].bcd, 1'b0);
                                nxt_st.ch[c].elem = nv;
                                if (st_ff.ch[c].mode[2]) begin
                                    nxt_st.ch[c].out = !(nv == 16'h0000 && !st_ff.ch[c].strobe_done);
                                    if (nv == 16'h0000) begin
                                        nxt_st.ch[c].strobe_done = 1'b1;
                                    end
                                end else if (nv == 16'h0000) begin
                                    nxt_st.ch[c].out     = 1'b1;
                                    nxt_st.ch[c].running = 1'b0;
                                end
                            end
                        end
                        3'h2: begin
                            // new count at trigger or cycle end.
                            if (st_ff.ch[c].load_pend || st_ff.ch[c].trig_pend || trig) begin
                                nxt_st.ch[c].elem      = st_ff.ch[c].hold;
                                nxt_st.ch[c].load_pend = 1'b0;
                                nxt_st.ch[c].running   = 1'b1;
                                nxt_st.ch[c].out       = 1'b1;
                            end else if (gate && st_ff.ch[c].running) begin
                                at_one = (st_ff.ch[c].elem == 16'h0002);
                                if (st_ff.ch[c].elem == 16'h0001) begin
                                    nxt_st.ch[c].elem = st_ff.ch[c].hold;
                                    nxt_st.ch[c].out  = 1'b1;
                                end else begin
                                    nxt_st.ch[c].elem = dec_by(st_ff.ch[c].elem, st_ff.ch[c].bcd, 1'b0);
                                    nxt_st.ch[c].out  = !at_one;
                                end
                            end
                        end
                        default: begin
                            if (st_ff.ch[c].load_pend || st_ff.ch[c].trig_pend || trig) begin
                                nxt_st.ch[c].elem      = sq_load(st_ff.ch[c].hold, st_ff.ch[c].bcd);
                                nxt_st.ch[c].load_pend = 1'b0;
                                nxt_st.ch[c].running   = 1'b1;
                                nxt_st.ch[c].out       = 1'b1;
                            end else if (gate && st_ff.ch[c].running) begin
                                nv = dec_by(st_ff.ch[c].elem, st_ff.ch[c].bcd, 1'b1);
                                if (nv == 16'h0000) begin
                                    nxt_st.ch[c].out  = !st_ff.ch[c].out;
                                    nxt_st.ch[c].elem = sq_load(st_ff.ch[c].hold, st_ff.ch[c].bcd);
                                end else begin
                                    nxt_st.ch[c].elem = nv;
                                end
                                // Odd count: the high half reloads the same count as the low half.
                                if (nv == 16'h0000 && st_ff.ch[c].hold[0] && st_ff.ch[c].out) begin
                                    nxt_st.ch[c].elem = sq_load(st_ff.ch[c].hold, st_ff.ch[c].bcd);
                                end
                            end
                        end
                    endcase
                end
            end

            if (wr_fire && st_ff.aw_addr[1:0] == 2'h0) begin
                if (st_ff.aw_addr == OFS_CTRL
                        && st_ff.w_data[CW_SEL_HI:CW_SEL_LO] == c[1:0]
                        && st_ff.w_data[CW_FMT_HI:CW_FMT_LO] != FMT_LATCH) begin
                    nxt_st.ch[c].fmt       = st_ff.w_data[CW_FMT_HI:CW_FMT_LO];
                    nxt_st.ch[c].mode      = st_ff.w_data[CW_MODE_HI:CW_MODE_LO];
                    nxt_st.ch[c].bcd       = st_ff.w_data[CW_BCD];
                    nxt_st.ch[c].elem      = CNT_RST;
                    nxt_st.ch[c].armed     = 1'b0;
                    nxt_st.ch[c].running   = 1'b0;
                    nxt_st.ch[c].load_pend = 1'b0;
                    nxt_st.ch[c].msb_next  = 1'b0;
                    // mode 0 output low on control write.
                    nxt_st.ch[c].out       = (st_ff.w_data[CW_MODE_HI:CW_MODE_LO] != MODE_RST);
                end else if (st_ff.aw_addr[3:2] == c[1:0] && wr_idx != 2'h3) begin
                    // host value kept in holding register.
                    if (st_ff.ch[c].fmt == FMT_LSB) begin
                        nxt_st.ch[c].hold = {8'h00, st_ff.w_data};
                    end else if (st_ff.ch[c].fmt == FMT_MSB) begin
                        nxt_st.ch[c].hold = {st_ff.w_data, 8'h00};
                    end else if (!st_ff.ch[c].msb_next) begin
                        nxt_st.ch[c].hold[7:0] = st_ff.w_data;
                    end else begin
                        nxt_st.ch[c].hold[15:8] = st_ff.w_data;
                    end
                    if (st_ff.ch[c].fmt == FMT_BOTH) begin
                        nxt_st.ch[c].msb_next = !st_ff.ch[c].msb_next;
                    end
                    if (st_ff.ch[c].fmt != FMT_BOTH || st_ff.ch[c].msb_next) begin
                        nxt_st.ch[c].armed = 1'b1;
                        if (st_ff.ch[c].mode[1] == 1'b0) begin
                            nxt_st.ch[c].load_pend = (st_ff.ch[c].mode[0] == 1'b0);
                        end else if (!st_ff.ch[c].armed) begin
                            nxt_st.ch[c].load_pend = 1'b1;
                        end
                    end else if (st_ff.ch[c].mode == MODE_RST) begin
                        nxt_st.ch[c].running = 1'b0;
                        nxt_st.ch[c].out     = 1'b0;
                    end
                end
            end
        end

        if (srst) begin
            nxt_st = '0;
            for (int c = 0; c < NUM_CH; c++) begin
                nxt_st.ch[c].out = 1'b1;
            end
            nxt_st.awready = 1'b1;
            nxt_st.wready  = 1'b1;
            nxt_st.arready = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        st_ff <= nxt_st;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            timer_outputs[c] = st_ff.ch[c].out;
        end
        s_axi_awready = st_ff.awready;
        s_axi_wready  = st_ff.wready;
        s_axi_bvalid  = st_ff.bvalid;
        s_axi_bresp   = st_ff.bresp;
        s_axi_arready = st_ff.arready;
        s_axi_rvalid  = st_ff.rvalid;
        s_axi_rdata   = st_ff.rdata;
        s_axi_rresp   = st_ff.rresp;
    end

endmodule
`default_nettype wire

// ### core/pit_pkg.sv
// Package of constants and types for the three-channel interval counter.
`default_nettype none
package pit_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] OFS_CNT0    = 4'h0;
    localparam logic [3:0] OFS_CNT1    = 4'h4;
    localparam logic [3:0] OFS_CNT2    = 4'h8;
    localparam logic [3:0] OFS_CTRL    = 4'hc;
    localparam int         NUM_CH      = 3;
    // ----------------------------------------------------------------
    // Control word fields
    // ----------------------------------------------------------------
    localparam int         CW_SEL_HI   = 7;
    localparam int         CW_SEL_LO   = 6;
    localparam int         CW_FMT_HI   = 5;
    localparam int         CW_FMT_LO   = 4;
    localparam int         CW_MODE_HI  = 3;
    localparam int         CW_MODE_LO  = 1;
    localparam int         CW_BCD      = 0;
    localparam logic [1:0] FMT_LATCH   = 2'h0;
    localparam logic [1:0] FMT_LSB     = 2'h1;
    localparam logic [1:0] FMT_MSB     = 2'h2;
    localparam logic [1:0] FMT_BOTH    = 2'h3;
    localparam logic [1:0] SEL_READBK  = 2'h3;
    localparam logic [2:0] MODE_RST    = 3'h0;
    localparam logic [15:0] CNT_RST    = 16'h0000;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ----------------------------------------------------------------
    // Counter state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  fmt;
        logic [2:0]  mode;
        logic        bcd;
        logic [15:0] hold;
        logic [15:0] elem;
        logic        out;
        logic        armed;
        logic        load_pend;
        logic        trig_pend;
        logic        msb_next;
        logic        gate_q;
        logic        running;
        logic        strobe_done;
    } chan_t;
endpackage
`default_nettype wire

// ### tb/axi_host_model.sv
// Host bus master model issuing register writes and reads.
`default_nettype none
module axi_host_model
(
    input  wire logic        clk_sys,
    output var  logic [3:0]  s_axi_awaddr,
    output var  logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output var  logic [31:0] s_axi_wdata,
    output var  logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output var  logic        s_axi_bready,
    output var  logic [3:0]  s_axi_araddr,
    output var  logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output var  logic        s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = 39'h0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = 6'h0;
    end
    task automatic wr(input logic [3:0] addr, input logic [7:0] data, output logic [1:0] resp);
        @(posedge clk_sys);
        s_axi_awaddr <= addr;
        s_axi_wdata <= {24'h000000, data};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] addr, output logic [31:0] data, output logic [1:0] resp);
        @(posedge clk_sys);
        s_axi_araddr <= addr;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### tb/interval_counter_modes_props.sv
// Port-level checks for the interval counter and its register port.
`default_nettype none
module interval_counter_modes_props
    import pit_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              srst,
    input wire logic [NUM_CH-1:0] count_clk_fall,
    input wire logic [NUM_CH-1:0] count_trigger_inputs,
    input wire logic [NUM_CH-1:0] timer_outputs,
    input wire logic [3:0]        s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid
);
    logic       cw_fire;
    logic [2:0] mode1_ff;
    // Both write halves must land together; the host model always offers them so.
    assign cw_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                     && s_axi_awaddr == OFS_CTRL && s_axi_wdata[5:4] != FMT_LATCH;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mode1_ff <= MODE_RST;
        end else if (cw_fire && s_axi_wdata[7:6] == 2'h1) begin
            mode1_ff <= s_axi_wdata[3:1];
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    AST_RST_HIGH: assert property (disable iff (1'b0) srst |=> timer_outputs == 3'h7)
        else $error("outputs not high after reset");
    AST_CW0_LOW: assert property (cw_fire && s_axi_wdata[7:6] == 2'h0 && s_axi_wdata[3:1] == MODE_RST
        |-> ##[1:3] !timer_outputs[0]) else $error("mode 0 control word left output high");
    AST_CW_HIGH: assert property (cw_fire && s_axi_wdata[7:6] == 2'h0 && s_axi_wdata[3:1] != MODE_RST
        |-> ##[1:3] timer_outputs[0]) else $error("control word left output low");
    AST_M2_GATE: assert property (mode1_ff[1:0] == 2'h2 && !count_trigger_inputs[1]
        |-> ##[0:3] timer_outputs[1]) else $error("low gate did not force output high");
    AST_M2_ONE_LOW: assert property (mode1_ff[1:0] == 2'h2 && !timer_outputs[1] && count_clk_fall[1]
        |-> ##[1:3] timer_outputs[1]) else $error("rate pulse longer than one count");
    AST_WR_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_RD_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    COV_CW: cover property (cw_fire);
    COV_RATE_PULSE: cover property (mode1_ff[1:0] == 2'h2 && $fell(timer_outputs[1]));
    COV_READ: cover property (s_axi_arvalid && s_axi_arready);
endmodule
`default_nettype wire

// ### tb/interval_counter_modes_tb.sv
// Self-checking bench for the interval counter.
`default_nettype none
module interval_counter_modes_tb import pit_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clk_sys;
    logic              srst;
    logic [NUM_CH-1:0] count_clk_fall;
    logic [NUM_CH-1:0] count_trigger_inputs;
    logic [NUM_CH-1:0] timer_outputs;
    logic [3:0]        s_axi_awaddr, s_axi_araddr;
    logic [3:0]        s_axi_wstrb = 4'h1;
    logic [31:0]       s_axi_wdata, s_axi_rdata;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int                miscompares;
    int                checks;
    interval_counter_modes interval_counter_modes_inst (.*);
    axi_host_model axi_host_model_inst (.*);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_chk(input logic [3:0] addr, input logic [7:0] data, input logic [1:0] exp);
        logic [1:0] resp;
        axi_host_model_inst.wr(addr, data, resp);
        cmp("write response", 16'(exp), 16'(resp));
    endtask
    task automatic rd_chk(input logic [3:0] addr, input logic [1:0] exp, output logic [31:0] data);
        logic [1:0] resp;
        axi_host_model_inst.rd(addr, data, resp);
        cmp("read response", 16'(exp), 16'(resp));
    endtask
    task automatic prog(input logic [7:0] cw, input logic [3:0] addr, input logic [7:0] cnt);
        wr_chk(OFS_CTRL, cw, RESP_OKAY);
        wr_chk(addr, cnt, RESP_OKAY);
    endtask
    // n counting-clock falling edges, each followed by time for the output to settle and a check.
    task automatic seq(input int ch, input int n, input logic [7:0] exp);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            count_clk_fall <= 3'(1 << ch);
            @(posedge clk_sys);
            count_clk_fall <= 3'h0;
            repeat (3) @(posedge clk_sys);
            cmp("timer output", 16'(exp[i]), 16'(timer_outputs[ch]));
        end
    endtask
    task automatic t_mode0();
        count_trigger_inputs <= 3'h7;
        wr_chk(OFS_CTRL, 8'h10, RESP_OKAY);
        cmp("output after control", 16'h0000, 16'(timer_outputs[0]));
        wr_chk(OFS_CNT0, 8'h03, RESP_OKAY);
        seq(0, 4, 8'h08);
        count_trigger_inputs[0] <= 1'b0;
        prog(8'h10, OFS_CNT0, 8'h02);
        seq(0, 3, 8'h00);
        count_trigger_inputs[0] <= 1'b1;
        seq(0, 2, 8'h02);
    endtask
    task automatic t_mode1();
        count_trigger_inputs[0] <= 1'b0;
        prog(8'h12, OFS_CNT0, 8'h02);
        seq(0, 1, 8'h01);
        repeat (2) begin
            count_trigger_inputs[0] <= 1'b1;
            seq(0, 3, 8'h04);
            count_trigger_inputs[0] <= 1'b0;
            seq(0, 1, 8'h01);
        end
    endtask
    task automatic t_mode2();
        prog(8'h54, OFS_CNT1, 8'h03);
        seq(1, 6, 8'h1b);
        count_trigger_inputs[1] <= 1'b0;
        repeat (2) @(posedge clk_sys);
        cmp("output with gate low", 16'h0001, 16'(timer_outputs[1]));
        count_trigger_inputs[1] <= 1'b1;
        seq(1, 3, 8'h03);
    endtask
    task automatic t_mode5();
        count_trigger_inputs[1] <= 1'b0;
        prog(8'h5a, OFS_CNT1, 8'h02);
        seq(1, 1, 8'h01);
        count_trigger_inputs[1] <= 1'b1;
        seq(1, 4, 8'h0b);
    endtask
    task automatic t_mode4_mode3();
        prog(8'h98, OFS_CNT2, 8'h02);
        seq(2, 4, 8'h0b);
        prog(8'h96, OFS_CNT2, 8'h04);
        seq(2, 1, 8'h01);
        seq(2, 4, 8'h09);
        seq(2, 4, 8'h09);
    endtask
    task automatic t_regs();
        logic [31:0] data;
        count_trigger_inputs[0] <= 1'b1;
        prog(8'h11, OFS_CNT0, 8'h00);
        seq(0, 2, 8'h00);
        rd_chk(OFS_CNT0, RESP_OKAY, data);
        cmp("counter 0 element", 16'h9999, data[15:0]);
        prog(8'ha8, OFS_CNT2, 8'h01);
        seq(2, 1, 8'h01);
        rd_chk(OFS_CNT2, RESP_OKAY, data);
        cmp("counter 2 element", 16'h0100, data[15:0]);
        wr_chk(4'h1, 8'h10, RESP_SLVERR);
        rd_chk(4'h2, RESP_SLVERR, data);
    endtask
    task automatic test_done();
        if (miscompares == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #100us;
        miscompares++;
        test_done();
    end
    initial begin
        {srst, count_clk_fall, count_trigger_inputs} = 7'h40;
        miscompares = 0;
        checks = 0;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        t_mode0();
        t_mode1();
        t_mode2();
        t_mode5();
        t_mode4_mode3();
        t_regs();
        test_done();
    end
endmodule
bind interval_counter_modes interval_counter_modes_props interval_counter_modes_props_inst (.*);
`default_nettype wire
